// *** pgate_defines.svh ***
// Purpose: constants of the port clock gate and soft reset block
// Assumes: 32-bit AHB-Lite register window, word aligned
// Notes: offsets are byte addresses within the block
// Functional notes
// - gate bit set clocks its port
// - access to unclocked port gives bus fault
// - all gate bits zero after reset
// - run, sleep, deep-sleep gates by power mode
// - sleep gates apply only with automatic gating
// - deep-sleep gate at 0x128, bits 7:0
// - reserved bits read zero, ignore writes
// - soft reset writes masked by capabilities
// - soft reset zero at reset, four writable bits
// - bit 24 resets bus controller zero
// - bit 16 resets converter module zero
// - bit 6 resets low power module
// - bit 3 resets watchdog
`ifndef PGATE_DEFINES_SVH
`define PGATE_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_SOFT_RESET 12'h040
`define OFS_RUN_CFG 12'h060
`define OFS_RUN_GATE 12'h108
`define OFS_SLEEP_GATE 12'h118
`define OFS_DEEP_GATE 12'h128
`define OFS_INT_STATUS 12'h200
`define OFS_INT_MASK 12'h204

// ****************************************
// fields and reset values
// ****************************************
`define GATE_RESET 8'h00
`define SOFT_RESET_RESET 32'h0000_0000
`define SOFT_RESET_WR_MASK 32'h0101_0048
`define BIT_BUS_CTRL_ZERO 24
`define BIT_ADC0 16
`define BIT_LOW_POWER 6
`define BIT_WATCHDOG 3
`define BIT_AUTO_GATE 27
`define EVT_PORT_FAULT 0
`define EVT_RESET_BLOCKED 1

`endif

// *** pgate_pkg.sv ***
// Purpose: types of the port clock gate and soft reset block
// Assumes: nothing beyond the defines header
// Notes: power mode codes are gray along run, sleep, deep sleep
package pgate_pkg;

	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_DEEP = 2'b11
	} power_mode_t;

	typedef struct packed {
		logic bus_controller_zero_reset;
		logic adc0;
		logic low_power_module_reset;
		logic watchdog_reset;
	} unit_reset_t;

	typedef struct packed {
		logic wr_pend;
		logic [11:0] addr;
		logic [7:0] run_gate;
		logic [7:0] sleep_gate;
		logic [7:0] deep_gate;
		logic [31:0] soft_reset;
		logic auto_gate;
		logic [1:0] int_sts;
		logic [1:0] int_msk;
		logic [7:0] clk_en;
		logic [31:0] rdata;
	} pgate_state_t;

endpackage : pgate_pkg

// *** pgate_ctrl.sv ***
// Purpose: port clock gating by power mode and unit soft reset control
// Assumes: zero wait state AHB-Lite slave, single word transfers
// Notes: gate enables and reset outputs come straight from flip-flops
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "pgate_defines.svh"

module pgate_ctrl
	import pgate_pkg::*;
#(
	parameter int NUM_PORTS = 8
) (
	input wire logic CORE_CLK, // system clock, 100 MHz
	input wire logic RESETN, // synchronous reset, active low
	input wire logic HSEL, // slave select
	input wire logic [31:0] HADDR, // byte address
	input wire logic [1:0] HTRANS, // transfer type
	input wire logic HWRITE, // write when high
	input wire logic [2:0] HSIZE, // word only
	input wire logic [31:0] HWDATA, // write data
	input wire logic HREADY, // bus ready
	output logic HREADYOUT, // always ready
	output logic HRESP, // always okay
	output logic [31:0] HRDATA, // read data
	input wire power_mode_t POWER_MODE, // current power state
	input wire logic [31:0] DEV_CAPS, // units present, one per soft reset bit
	input wire logic PORT_ACC_VALID, // an access to a port this cycle
	input wire logic [2:0] PORT_ACC_IDX, // which port, 0 is A
	output logic PORT_ACC_FAULT, // access must end in a bus fault
	output logic [NUM_PORTS-1:0] PORT_CLK_EN, // clock enable per port
	output unit_reset_t UNIT_RESET, // held resets of governed units
	output logic IRQ // level interrupt
);

	pgate_state_t st_q;
	pgate_state_t st_d;
	logic addr_take;
	logic wr_now;
	logic [31:0] wr_en_bits;
	logic blocked;
	logic [7:0] sel_gate;
	logic [1:0] evt;
	logic [1:0] w1c;
	logic [NUM_PORTS-1:0] port_off;

	// ****************************************
	// bus address phase and write strobe
	// ****************************************
	assign addr_take = HSEL && HTRANS[1] && HREADY;
	assign wr_now = st_q.wr_pend;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = st_q.rdata;

	// ****************************************
	// outputs from registered state
	// ****************************************
	assign PORT_CLK_EN = st_q.clk_en[NUM_PORTS-1:0];
	assign UNIT_RESET.bus_controller_zero_reset = st_q.soft_reset[`BIT_BUS_CTRL_ZERO];
	assign UNIT_RESET.adc0 = st_q.soft_reset[`BIT_ADC0];
	assign UNIT_RESET.low_power_module_reset = st_q.soft_reset[`BIT_LOW_POWER];
	assign UNIT_RESET.watchdog_reset = st_q.soft_reset[`BIT_WATCHDOG];
	assign IRQ = |(st_q.int_sts & st_q.int_msk);

	// ****************************************
	// per port gate state
	// ****************************************
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		assign port_off[p] = !st_q.clk_en[p];
	end

	// a port whose gate is off cannot answer, so the access is faulted
	assign PORT_ACC_FAULT = PORT_ACC_VALID && port_off[PORT_ACC_IDX];

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		evt = 2'b00;
		w1c = 2'b00;
		blocked = 1'b0;
		sel_gate = st_q.run_gate;
		// only bits that are writable and whose unit exists may change
		wr_en_bits = `SOFT_RESET_WR_MASK & DEV_CAPS;
		st_d.wr_pend = addr_take && HWRITE;
		if (addr_take) begin
			st_d.addr = HADDR[11:0];
		end
		if (wr_now) begin
			case (st_q.addr)
				`OFS_SOFT_RESET: begin
					st_d.soft_reset = (st_q.soft_reset & ~wr_en_bits)
						| (HWDATA & wr_en_bits);
					blocked = |(HWDATA & `SOFT_RESET_WR_MASK & ~DEV_CAPS);
				end
				`OFS_RUN_CFG: begin
					st_d.auto_gate = HWDATA[`BIT_AUTO_GATE];
				end
				`OFS_RUN_GATE: begin
					st_d.run_gate = HWDATA[7:0];
				end
				`OFS_SLEEP_GATE: begin
					st_d.sleep_gate = HWDATA[7:0];
				end
				`OFS_DEEP_GATE: begin
					st_d.deep_gate = HWDATA[7:0];
				end
				`OFS_INT_STATUS: begin
					w1c = HWDATA[1:0];
				end
				`OFS_INT_MASK: begin
					st_d.int_msk = HWDATA[1:0];
				end
				default: begin
					st_d.int_msk = st_q.int_msk;
				end
			endcase
		end
		evt[`EVT_PORT_FAULT] = PORT_ACC_FAULT;
		evt[`EVT_RESET_BLOCKED] = blocked;
		// a new event wins over a clear in the same cycle
		st_d.int_sts = (st_q.int_sts & ~w1c) | evt;
		// without automatic gating the run gate governs every mode
		if (st_q.auto_gate) begin
			case (POWER_MODE)
				MODE_RUN: begin
					sel_gate = st_q.run_gate;
				end
				MODE_SLEEP: begin
					sel_gate = st_q.sleep_gate;
				end
				MODE_DEEP: begin
					sel_gate = st_q.deep_gate;
				end
				default: begin
					sel_gate = st_q.run_gate;
				end
			endcase
		end
		st_d.clk_en = sel_gate;
		// read mux looks at next values so a read right after a write sees it
		st_d.rdata = 32'h0000_0000;
		if (addr_take && !HWRITE) begin
			case (HADDR[11:0])
				`OFS_SOFT_RESET: begin
					st_d.rdata = st_d.soft_reset;
				end
				`OFS_RUN_CFG: begin
					st_d.rdata[`BIT_AUTO_GATE] = st_d.auto_gate;
				end
				`OFS_RUN_GATE: begin
					st_d.rdata[7:0] = st_d.run_gate;
				end
				`OFS_SLEEP_GATE: begin
					st_d.rdata[7:0] = st_d.sleep_gate;
				end
				`OFS_DEEP_GATE: begin
					st_d.rdata[7:0] = st_d.deep_gate;
				end
				`OFS_INT_STATUS: begin
					st_d.rdata[1:0] = st_d.int_sts;
				end
				`OFS_INT_MASK: begin
					st_d.rdata[1:0] = st_d.int_msk;
				end
				default: begin
					st_d.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_gate_reset_zero: assert property (@(posedge CORE_CLK)
		!RESETN |=> (PORT_CLK_EN == '0 && st_q.deep_gate == `GATE_RESET))
		else $error("gates not zero after reset");

	a_clk_en_follows: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		$past(RESETN) && $past(!st_q.auto_gate) |-> PORT_CLK_EN == $past(st_q.run_gate))
		else $error("clock enable does not follow run gate");

	a_fault_unclocked: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		PORT_ACC_VALID && PORT_CLK_EN[PORT_ACC_IDX] == 1'b0 |-> PORT_ACC_FAULT
		##1 st_q.int_sts[`EVT_PORT_FAULT])
		else $error("unclocked access not faulted");

	a_deep_mode_sel: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		st_q.auto_gate && POWER_MODE == MODE_DEEP ##1 $past(RESETN)
		|-> PORT_CLK_EN == $past(st_q.deep_gate))
		else $error("deep sleep gate not applied");

	a_sleep_mode_sel: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		st_q.auto_gate && POWER_MODE == MODE_SLEEP |=> PORT_CLK_EN == $past(st_q.sleep_gate))
		else $error("sleep gate not applied");

	a_deep_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		addr_take && HWRITE && HADDR[11:0] == `OFS_DEEP_GATE
		##1 1'b1 |=> st_q.deep_gate == $past(HWDATA[7:0]))
		else $error("deep gate write lost");

	a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		$past(addr_take && !HWRITE && HADDR[11:0] == `OFS_DEEP_GATE) |-> HRDATA[31:8] == 24'h00_0000)
		else $error("reserved gate bits not zero");

	a_reset_reserved: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(st_q.soft_reset & ~(`SOFT_RESET_WR_MASK)) == 32'h0000_0000)
		else $error("soft reset reserved bits set");

	a_reset_masked: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		wr_now && st_q.addr == `OFS_SOFT_RESET && !DEV_CAPS[`BIT_WATCHDOG]
		|=> UNIT_RESET.watchdog_reset == $past(UNIT_RESET.watchdog_reset))
		else $error("soft reset write not masked");

	a_reset_hold: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		UNIT_RESET.bus_controller_zero_reset && !(wr_now && st_q.addr == `OFS_SOFT_RESET)
		|=> UNIT_RESET.bus_controller_zero_reset)
		else $error("unit reset dropped without a write");

	a_irq_level: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		st_q.int_sts[0] && st_q.int_msk[0] |-> IRQ)
		else $error("interrupt not raised");

	// ****************************************
	// checks of register writes and reads
	// ****************************************
	a_reset_outputs: assert property (@(posedge CORE_CLK)
		!RESETN |=> UNIT_RESET == '0 && IRQ == 1'b0 && HRDATA == 32'h0000_0000)
		else $error("outputs not cleared by reset");

	a_run_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		addr_take && HWRITE && HADDR[11:0] == `OFS_RUN_GATE
		##1 1'b1 |=> st_q.run_gate == $past(HWDATA[7:0]))
		else $error("run gate write lost");

	a_sleep_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		addr_take && HWRITE && HADDR[11:0] == `OFS_SLEEP_GATE
		##1 1'b1 |=> st_q.sleep_gate == $past(HWDATA[7:0]))
		else $error("sleep gate write lost");

	a_auto_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		addr_take && HWRITE && HADDR[11:0] == `OFS_RUN_CFG
		##1 1'b1 |=> st_q.auto_gate == $past(HWDATA[`BIT_AUTO_GATE]))
		else $error("automatic gating write lost");

	a_mask_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		addr_take && HWRITE && HADDR[11:0] == `OFS_INT_MASK
		##1 1'b1 |=> st_q.int_msk == $past(HWDATA[1:0]))
		else $error("interrupt mask write lost");

	a_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		!$past(addr_take && !HWRITE) |-> HRDATA == 32'h0000_0000)
		else $error("read data not zero outside a read");

	a_gate_read_reserved: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		$past(addr_take && !HWRITE && (HADDR[11:0] == `OFS_RUN_GATE
		|| HADDR[11:0] == `OFS_SLEEP_GATE)) |-> HRDATA[31:8] == 24'h00_0000)
		else $error("reserved gate bits not zero");

	a_soft_read_reserved: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		$past(addr_take && !HWRITE && HADDR[11:0] == `OFS_SOFT_RESET)
		|-> (HRDATA & ~(`SOFT_RESET_WR_MASK)) == 32'h0000_0000)
		else $error("reserved soft reset bits not zero");

	a_cfg_read_reserved: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		$past(addr_take && !HWRITE && HADDR[11:0] == `OFS_RUN_CFG)
		|-> (HRDATA & ~(32'h0000_0001 << `BIT_AUTO_GATE)) == 32'h0000_0000)
		else $error("reserved config bits not zero");

	a_int_read_reserved: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		$past(addr_take && !HWRITE && (HADDR[11:0] == `OFS_INT_STATUS
		|| HADDR[11:0] == `OFS_INT_MASK)) |-> HRDATA[31:2] == 30'h0000_0000)
		else $error("reserved interrupt bits not zero");

	// ****************************************
	// checks of gating and port faults
	// ****************************************
	a_run_mode_sel: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		st_q.auto_gate && POWER_MODE == MODE_RUN |=> PORT_CLK_EN == $past(st_q.run_gate))
		else $error("run gate not applied");

	a_manual_deep: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		!st_q.auto_gate && POWER_MODE == MODE_DEEP |=> PORT_CLK_EN == $past(st_q.run_gate))
		else $error("deep gate applied without automatic gating");

	a_clocked_no_fault: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		PORT_ACC_VALID && PORT_CLK_EN[PORT_ACC_IDX] |-> !PORT_ACC_FAULT)
		else $error("clocked port access faulted");

	a_fault_needs_access: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		!PORT_ACC_VALID |-> !PORT_ACC_FAULT)
		else $error("fault without an access");

	// ****************************************
	// checks of soft resets and interrupts
	// ****************************************
	a_bus_zero_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		wr_now && st_q.addr == `OFS_SOFT_RESET && DEV_CAPS[`BIT_BUS_CTRL_ZERO]
		|=> UNIT_RESET.bus_controller_zero_reset == $past(HWDATA[`BIT_BUS_CTRL_ZERO]))
		else $error("bus controller reset write lost");

	a_conv_zero_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		wr_now && st_q.addr == `OFS_SOFT_RESET && DEV_CAPS[`BIT_ADC0]
		|=> UNIT_RESET.adc0 == $past(HWDATA[`BIT_ADC0]))
		else $error("converter reset write lost");

	a_low_power_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		wr_now && st_q.addr == `OFS_SOFT_RESET && DEV_CAPS[`BIT_LOW_POWER]
		|=> UNIT_RESET.low_power_module_reset == $past(HWDATA[`BIT_LOW_POWER]))
		else $error("low power module reset write lost");

	a_watchdog_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		wr_now && st_q.addr == `OFS_SOFT_RESET && DEV_CAPS[`BIT_WATCHDOG]
		|=> UNIT_RESET.watchdog_reset == $past(HWDATA[`BIT_WATCHDOG]))
		else $error("watchdog reset write lost");

	a_reset_stays_off: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		!UNIT_RESET.bus_controller_zero_reset && !(wr_now && st_q.addr == `OFS_SOFT_RESET)
		|=> !UNIT_RESET.bus_controller_zero_reset)
		else $error("unit reset raised without a write");

	a_blocked_event: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		wr_now && st_q.addr == `OFS_SOFT_RESET && |(HWDATA & `SOFT_RESET_WR_MASK & ~DEV_CAPS)
		|=> st_q.int_sts[`EVT_RESET_BLOCKED])
		else $error("blocked soft reset write not flagged");

	a_status_clear: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		wr_now && st_q.addr == `OFS_INT_STATUS && HWDATA[0] && !PORT_ACC_FAULT
		|=> !st_q.int_sts[`EVT_PORT_FAULT])
		else $error("status bit not cleared");

	a_set_wins: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		wr_now && st_q.addr == `OFS_INT_STATUS && HWDATA[0] && PORT_ACC_FAULT
		|=> st_q.int_sts[`EVT_PORT_FAULT])
		else $error("fault lost against a clear");

	a_irq_off: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(st_q.int_sts & st_q.int_msk) == 2'b00 |-> !IRQ)
		else $error("interrupt raised with nothing pending");

endmodule : pgate_ctrl

// *** pgate_ctrl_bench.sv ***
// Purpose: self-checking bench of the port clock gate and soft reset block
// Assumes: zero wait state slave, hready of the bus is the slave's hreadyout
// Notes: random data from an lfsr with a fixed start; corner cases among it
`timescale 1ns/1ns
`include "pgate_defines.svh"

module pgate_ctrl_bench;
	import pgate_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout, hresp, port_acc_fault, irq;
	logic [31:0] hrdata;
	power_mode_t power_mode = MODE_RUN;
	logic [31:0] dev_caps = 32'hffff_ffff;
	logic port_acc_valid = 1'b0;
	logic [2:0] port_acc_idx = 3'h0;
	logic [7:0] port_clk_en;
	unit_reset_t unit_reset;
	int bad_count = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h969f_a053;
	logic [31:0] rd, w, e;
	logic [7:0] g [3];
	power_mode_t modes [3] = '{MODE_RUN, MODE_SLEEP, MODE_DEEP};

	always #5 core_clk = ~core_clk;

	pgate_ctrl u_dut (.CORE_CLK(core_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
		.HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
		.POWER_MODE(power_mode), .DEV_CAPS(dev_caps), .PORT_ACC_VALID(port_acc_valid),
		.PORT_ACC_IDX(port_acc_idx), .PORT_ACC_FAULT(port_acc_fault),
		.PORT_CLK_EN(port_clk_en), .UNIT_RESET(unit_reset), .IRQ(irq));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand

	// enable expected from gates, auto gating and mode
	function automatic logic [7:0] exp_en(input logic auto, input power_mode_t m);
		if (!auto || m == MODE_RUN) begin
			return g[0];
		end
		return (m == MODE_SLEEP) ? g[1] : g[2];
	endfunction : exp_en

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	// one single transfer; read data taken at the edge that ends the data phase
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0_0000, a};
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic tally_and_finish;
		if (bad_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		tick(8);
		resetn <= 1'b1;
		tick(1);
		check("clk_en", 32'h0, {24'h0, port_clk_en});
		check("unit_reset", 32'h0, {28'h0, unit_reset});
		check("hresp", 32'h0, {31'h0, hresp});
		check("hreadyout", 32'h1, {31'h0, hreadyout});
		bus(1'b0, `OFS_SOFT_RESET, 32'h0);
		check("soft_reset", 32'h0, rd);
		bus(1'b0, `OFS_DEEP_GATE, 32'h0);
		check("deep_gate", 32'h0, rd);
		bus(1'b0, 12'h3f0, 32'h0);
		check("unmapped", 32'h0, rd);
		// gates with random reserved bits; deep gate keeps only 7:0
		for (int i = 0; i < 3; i++) begin
			seed = next_rand(seed);
			g[i] = seed[7:0];
			bus(1'b1, (i == 0) ? `OFS_RUN_GATE : (i == 1) ? `OFS_SLEEP_GATE : `OFS_DEEP_GATE, seed);
		end
		bus(1'b0, `OFS_DEEP_GATE, 32'h0);
		check("deep_gate", {24'h0, g[2]}, rd);
		for (int a = 0; a < 2; a++) begin
			bus(1'b1, `OFS_RUN_CFG, a ? 32'h0800_0000 : 32'h0);
			foreach (modes[m]) begin
				power_mode <= modes[m];
				tick(3);
				check("clk_en", {24'h0, exp_en(a[0], modes[m])}, {24'h0, port_clk_en});
			end
		end
		// faults with interrupt masked, then unmasked, then cleared
		bus(1'b1, `OFS_INT_MASK, 32'h0);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			port_acc_valid <= 1'b1;
			port_acc_idx <= i[2:0];
			#1;
			check("fault", {31'h0, ~g[2][i]}, {31'h0, port_acc_fault});
		end
		@(posedge core_clk);
		port_acc_valid <= 1'b0;
		tick(2);
		check("irq", 32'h0, {31'h0, irq});
		bus(1'b0, `OFS_INT_STATUS, 32'h0);
		check("status", {31'h0, g[2] != 8'hff}, rd);
		bus(1'b1, `OFS_INT_MASK, 32'h3);
		tick(2);
		check("irq", {31'h0, g[2] != 8'hff}, {31'h0, irq});
		bus(1'b1, `OFS_INT_STATUS, 32'h3);
		tick(2);
		check("irq", 32'h0, {31'h0, irq});
		// soft reset masked by capabilities; last pass is the all-ones corner
		for (int i = 0; i < 5; i++) begin
			dev_caps <= 32'hffff_ffff;
			bus(1'b1, `OFS_SOFT_RESET, 32'h0);
			seed = next_rand(seed);
			dev_caps <= (i == 4) ? 32'hffff_ffff : seed;
			w = (i == 4) ? 32'hffff_ffff : next_rand(seed);
			e = w & 32'h0101_0048 & ((i == 4) ? 32'hffff_ffff : seed);
			bus(1'b1, `OFS_SOFT_RESET, w);
			tick(1);
			check("unit_reset", {28'h0, e[24], e[16], e[6], e[3]}, {28'h0, unit_reset});
			bus(1'b0, `OFS_SOFT_RESET, 32'h0);
			check("soft_reset", e, rd);
			bus(1'b0, `OFS_INT_STATUS, 32'h0);
			check("blocked", {30'h0, |(w & 32'h0101_0048 & ~e), 1'b0}, rd & 32'h2);
			bus(1'b1, `OFS_INT_STATUS, 32'h3);
			dev_caps <= 32'h0;
			bus(1'b1, `OFS_SOFT_RESET, 32'h0);
			bus(1'b0, `OFS_SOFT_RESET, 32'h0);
			check("soft_reset", e, rd);
		end
		dev_caps <= 32'hffff_ffff;
		bus(1'b1, `OFS_SOFT_RESET, 32'h0);
		tick(1);
		check("unit_reset", 32'h0, {28'h0, unit_reset});
		tally_and_finish();
	end

endmodule : pgate_ctrl_bench
